// ===== core/tbr_pkg.sv
package tbr_pkg;
	// register indices on the plain port (byte address = index)
	localparam logic [3:0] TBR_ADDR_WIDTH   = 4'h4;
	localparam logic [3:0] TBR_OFS_WORD_HI  = 4'h0;
	localparam logic [3:0] TBR_OFS_WORD_LO  = 4'h1;
	localparam logic [3:0] TBR_OFS_COUNT    = 4'h2;
	localparam logic [3:0] TBR_OFS_CCX      = 4'h3;
	localparam logic [3:0] TBR_OFS_CCH      = 4'h4;
	localparam logic [3:0] TBR_OFS_CCL      = 4'h5;
	// count register fields
	localparam int         TBR_FULL_BIT     = 7;
	localparam int         TBR_TALLY_MSB    = 5;
	localparam int         TBR_DEPTH        = 64;
	localparam logic [5:0] TBR_TALLY_RESET  = 6'h00;
	// extension register fields
	localparam int         TBR_PSEL_MSB     = 7;
	localparam int         TBR_PSEL_LSB     = 6;
	localparam int         TBR_EXT_MSB      = 5;
	localparam logic [7:0] TBR_CCX_RESET    = 8'h00;
	localparam logic [15:0] TBR_CC_RESET    = 16'h0000;
	// page types after ignoring the upper select bit
	localparam logic       TBR_PAGE_NONE    = 1'b0;
	localparam logic       TBR_PAGE_PROGRAM = 1'b1;
endpackage : tbr_pkg

// ===== core/tbr_trace_ram.sv
`timescale 1ns/10ps
// capture storage: one write port from the capture engine, one read port
module tbr_trace_ram (
	input  wire logic        i_core_clk, // clock
	input  wire logic        i_wr_en,    // write strobe
	input  wire logic [5:0]  i_wr_addr,  // write index
	input  wire logic [15:0] i_wr_data,  // captured word
	input  wire logic [5:0]  i_rd_addr,  // read index
	output logic      [15:0] o_rd_data   // combinational read
);
	logic [15:0] mem [0:63];

	// no reset: contents are whatever was last captured
	always_ff @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	assign o_rd_data = mem[i_rd_addr];
endmodule : tbr_trace_ram

// ===== core/tbr_page_compare.sv
`timescale 1ns/10ps
// comparator C address match with page extension
module tbr_page_compare (
	input  wire logic        i_psel_low,   // page select with bit 7 dropped
	input  wire logic [5:0]  i_ext_bits,   // extended compare bits
	input  wire logic [15:0] i_cmp_addr,   // compare address 15:0
	input  wire logic [7:0]  i_prog_page,  // program page value
	input  wire logic [15:0] i_addr,       // core address 15:0
	output logic             o_match       // address match
);
	import tbr_pkg::*;

	wire logic [21:0] ext_addr;
	wire logic        low_match;
	wire logic        ext_match;

	// page value supplies bits 21:14; bits 13:0 come from the plain bus
	assign ext_addr  = {i_prog_page, i_addr[13:0]};
	assign low_match = (i_psel_low == TBR_PAGE_PROGRAM) ?
		(i_cmp_addr == ext_addr[15:0]) : (i_cmp_addr == i_addr);
	assign ext_match = (i_psel_low == TBR_PAGE_NONE) ||
		(i_ext_bits == ext_addr[21:16]);
	assign o_match   = low_match && ext_match;
endmodule : tbr_page_compare

// ===== core/tbr_trace_readout.sv
`timescale 1ns/10ps
module tbr_trace_readout (
	input  wire logic                         i_core_clk,     // bus clock
	input  wire logic                         i_sys_rst,      // sync reset, active high
	input  wire logic [tbr_pkg::TBR_ADDR_WIDTH-1:0] i_addr,   // register byte address
	input  wire logic [15:0]                  i_wdata,        // write data
	input  wire logic                         i_wr,           // write strobe
	input  wire logic                         i_rd,           // read strobe
	input  wire logic                         i_word,         // 1: 16-bit access, 0: byte
	input  wire logic                         i_arm_write,    // software writes one to arm
	input  wire logic                         i_session_en,   // session armed level
	input  wire logic                         i_begin_mode,   // 1 begin-trigger, 0 end-trigger
	input  wire logic                         i_break_en,     // break on completion enable
	input  wire logic                         i_loop1_mode,   // capture mode is loop1
	input  wire logic                         i_capture,      // capture engine stores a word
	input  wire logic [15:0]                  i_capture_data, // word to store
	input  wire logic                         i_cmp_c_en,     // comparator C break enable
	input  wire logic [7:0]                   i_prog_page,    // program page value
	input  wire logic [15:0]                  i_core_addr,    // core address 15:0
	input  wire logic                         i_core_cycle,   // core bus cycle valid
	output logic      [15:0]                  o_rdata,        // read data, cycle after strobe
	output logic                              o_disarm,       // pulse: clear session enable
	output logic                              o_break_req,    // pulse: CPU break request
	output logic                              o_cmp_c_match   // comparator C match pulse
);
	import tbr_pkg::*;

	logic [5:0]  rd_ptr;
	logic [5:0]  tally;
	logic        full;
	logic [7:0]  ccx;
	logic [15:0] cch_ccl;

	wire logic        next_rd_valid;
	wire logic        hit_word;
	wire logic        word_read_ok;
	wire logic [15:0] ram_word;
	wire logic        capture_ok;
	wire logic [5:0]  next_tally;
	wire logic        wrap;
	wire logic        psel_low;
	wire logic        addr_match;
	wire logic [15:0] next_rdata;
	wire logic [7:0]  count_view;

	function automatic logic is_reg(input logic [3:0] a, input logic [3:0] ofs);
		is_reg = (a == ofs);
	endfunction : is_reg

	// readout is a 16-bit word only at the even (high) address
	assign hit_word     = i_rd && is_reg(i_addr, TBR_OFS_WORD_HI) && i_word;
	// byte, odd address or armed session yields zero and holds pointer
	assign word_read_ok = hit_word && !i_session_en;
	assign next_rd_valid = word_read_ok;

	tbr_trace_ram u_ram (
		.i_core_clk (i_core_clk),
		.i_wr_en    (capture_ok),
		.i_wr_addr  (tally),
		.i_wr_data  (i_capture_data),
		.i_rd_addr  (rd_ptr),
		.o_rd_data  (ram_word)
	);

	// storing stops when session enable drops (begin-trigger requests that at the first wrap) and is skipped in an arm-write cycle; end-trigger keeps storing
	assign capture_ok = i_capture && i_session_en && !i_arm_write;
	assign next_tally = 6'(tally + 6'h01);
	assign wrap       = capture_ok && (next_tally == TBR_TALLY_RESET);

	assign psel_low = ccx[TBR_PSEL_LSB];

	tbr_page_compare u_cmp (
		.i_psel_low  (psel_low),
		.i_ext_bits  (ccx[TBR_EXT_MSB:0]),
		.i_cmp_addr  (cch_ccl),
		.i_prog_page (i_prog_page),
		.i_addr      (i_core_addr),
		.o_match     (addr_match)
	);

	assign count_view = {full, 1'b0, tally};
	// loop1 leaves comparator C out of breakpoint use
	assign next_rdata =
		word_read_ok                     ? ram_word :
		(i_rd && is_reg(i_addr, TBR_OFS_COUNT)) ? {8'h00, count_view} :
		(i_rd && is_reg(i_addr, TBR_OFS_CCX))   ? {8'h00, ccx} :
		(i_rd && is_reg(i_addr, TBR_OFS_CCH))   ? {8'h00, cch_ccl[15:8]} :
		(i_rd && is_reg(i_addr, TBR_OFS_CCL))   ? {8'h00, cch_ccl[7:0]} :
		16'h0000;

	always_ff @(posedge i_core_clk) begin
		o_rdata <= i_sys_rst ? 16'h0000 : next_rdata;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rd_ptr <= TBR_TALLY_RESET;
		end else if (i_arm_write) begin
			rd_ptr <= TBR_TALLY_RESET;
		end else if (next_rd_valid) begin
			rd_ptr <= 6'(rd_ptr + 6'h01);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_arm_write) begin
			tally <= TBR_TALLY_RESET;
			full  <= 1'b0;
		end else if (capture_ok) begin
			tally <= next_tally;
			if (wrap) begin
				full <= 1'b1;
			end
		end
	end

	// completion in begin-trigger: 64th word stored
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_disarm    <= 1'b0;
			o_break_req <= 1'b0;
		end else begin
			o_disarm    <= wrap && i_begin_mode;
			o_break_req <= (wrap && i_begin_mode && i_break_en) ||
				(addr_match && i_core_cycle && i_cmp_c_en && !i_loop1_mode);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_cmp_c_match <= 1'b0;
		end else begin
			o_cmp_c_match <= addr_match && i_core_cycle;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ccx     <= TBR_CCX_RESET;
			cch_ccl <= TBR_CC_RESET;
		end else if (i_wr) begin
			if (is_reg(i_addr, TBR_OFS_CCX)) begin
				ccx <= i_wdata[7:0];
			end
			if (is_reg(i_addr, TBR_OFS_CCH)) begin
				cch_ccl[15:8] <= i_wdata[7:0];
			end
			if (is_reg(i_addr, TBR_OFS_CCL)) begin
				cch_ccl[7:0] <= i_wdata[7:0];
			end
		end
	end
endmodule : tbr_trace_readout

// ===== tb/tbr_readout_props.sv
`timescale 1ns/10ps
module tbr_readout_props (
	input wire logic        i_core_clk, i_sys_rst, i_rd, i_word, i_arm_write, i_session_en,
	input wire logic        i_begin_mode, i_break_en, i_loop1_mode, i_capture, i_cmp_c_en,
	input wire logic        i_core_cycle, o_disarm, o_break_req, o_cmp_c_match,
	input wire logic [3:0]  i_addr,
	input wire logic [15:0] o_rdata
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	a_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
		else $error("stray read data");
	a_byte_zero: assert property ($past(i_rd && i_addr == 4'h0 && !i_word) |-> o_rdata == 16'h0)
		else $error("byte read not zero");
	a_odd_zero: assert property ($past(i_rd && i_addr == 4'h1) |-> o_rdata == 16'h0)
		else $error("misaligned read not zero");
	a_armed_zero: assert property ($past(i_rd && i_addr == 4'h0 && i_session_en) |-> o_rdata == 16'h0)
		else $error("armed read not zero");
	a_arm_clears: assert property (i_arm_write ##1 (i_rd && i_addr == 4'h2 && !i_capture) |=> o_rdata == 16'h0)
		else $error("count not cleared by arming");
	a_disarm_cause: assert property (o_disarm |-> $past(i_capture && i_session_en && i_begin_mode))
		else $error("disarm without begin capture");
	a_break_cause: assert property (o_break_req |-> $past(i_break_en || (i_cmp_c_en && !i_loop1_mode)))
		else $error("break without enable");
	a_match_cause: assert property (o_cmp_c_match |-> $past(i_core_cycle))
		else $error("match without core cycle");
	c_disarm: cover property (o_disarm);
	c_match: cover property (o_cmp_c_match);
	c_word: cover property ($past(i_rd && i_addr == 4'h0 && i_word && !i_session_en));
endmodule : tbr_readout_props
bind tbr_trace_readout tbr_readout_props u_props (.i_core_clk, .i_sys_rst, .i_rd, .i_word,
	.i_arm_write, .i_session_en, .i_begin_mode, .i_break_en, .i_loop1_mode, .i_capture,
	.i_cmp_c_en, .i_core_cycle, .o_disarm, .o_break_req, .o_cmp_c_match, .i_addr, .o_rdata);

// ===== tb/tbr_core_model.sv
`timescale 1ns/10ps
module tbr_core_model (
	input  wire logic        i_core_clk,   // clock
	input  wire logic        i_go,         // present one core cycle
	input  wire logic [7:0]  i_page,       // page to present
	input  wire logic [15:0] i_addr,       // address to present
	output logic      [7:0]  o_prog_page,  // program page value
	output logic      [15:0] o_core_addr,  // core address
	output logic             o_core_cycle  // cycle valid
);
	initial {o_prog_page, o_core_addr, o_core_cycle} = '0;
	// idle lines keep toggling so a stale value never looks valid
	always @(posedge i_core_clk) begin
		o_core_cycle <= i_go;
		o_prog_page  <= i_go ? i_page : ~o_prog_page;
		o_core_addr  <= i_go ? i_addr : ~o_core_addr;
	end
endmodule : tbr_core_model

// ===== tb/tbr_trace_readout_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin bad_count++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module tbr_trace_readout_tb_top;
	import tbr_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, word = 0, arm = 0, sess = 0, bgn = 0, brk = 0;
	logic loop1 = 0, cap = 0, ccen = 0, go = 0, seen = 0, cyc_v, match, dis, brq;
	logic [3:0]  addr = '0;
	logic [7:0]  pg = '0, ppg;
	logic [15:0] wd = '0, cd = '0, cadr = '0, lf = 16'h3B51, rdata, caddr, ev;
	logic [15:0] mem [64];
	logic [15:0] exp_q [$];
	int bad_count = 0, comparisons = 0, cyc = 0, n_dis = 0, n_brk = 0, n_m = 0, wp = 0, em = 0;
	tbr_trace_readout u_tbr_trace_readout (.i_core_clk(clk), .i_sys_rst(rst), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_word(word), .i_arm_write(arm), .i_session_en(sess),
		.i_begin_mode(bgn), .i_break_en(brk), .i_loop1_mode(loop1), .i_capture(cap),
		.i_capture_data(cd), .i_cmp_c_en(ccen), .i_prog_page(ppg), .i_core_addr(caddr),
		.i_core_cycle(cyc_v), .o_rdata(rdata), .o_disarm(dis), .o_break_req(brq),
		.o_cmp_c_match(match));
	tbr_core_model u_tbr_core_model (.i_core_clk(clk), .i_go(go), .i_page(pg), .i_addr(cadr),
		.o_prog_page(ppg), .o_core_addr(caddr), .o_core_cycle(cyc_v));
	always #5 clk = ~clk;
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		seen <= rd;
		cyc++;
		n_m += int'(match);
		n_brk += int'(brq);
		// the control register drops the session when the block asks for it
		if (dis) begin
			n_dis++;
			sess <= 1'b0;
		end
		if (cyc == 2000) begin
			bad_count++;
			complete_run();
		end
	end
	always @(negedge clk) if (seen) begin
		ev = exp_q.pop_front();
		`CHK("rdata", ev, rdata)
	end
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic b);
		@(posedge clk);
		{arm, cap, go, wr, rd} <= {3'b000, w, !w};
		addr <= a;
		wd <= d;
		word <= b;
		if (!w) exp_q.push_back(d);
	endtask : bus
	task automatic arm_on(input logic b);
		@(posedge clk);
		{arm, cap, go, wr, rd} <= 5'b10000;
		{sess, bgn, brk} <= {1'b1, b, b};
		wp = 0;
	endtask : arm_on
	task automatic capture(input int n);
		repeat (n) begin
			@(posedge clk);
			{arm, cap, go, wr, rd} <= 5'b01000;
			lf = nx(lf);
			cd <= lf;
			mem[wp % 64] = lf;
			wp++;
		end
	endtask : capture
	task automatic core(input logic [7:0] p, input logic [15:0] a, input int e);
		@(posedge clk);
		{arm, cap, go, wr, rd} <= 5'b00100;
		pg <= p;
		cadr <= a;
		repeat (4) @(posedge clk) go <= 1'b0;
		`CHK("match", e, n_m)
	endtask : core
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		bus(0, TBR_OFS_COUNT, 16'h0000, 0);
		bus(1, TBR_OFS_CCX, 16'h00C5, 0);
		bus(0, TBR_OFS_CCX, 16'h00C5, 0);
		bus(1, 4'hF, 16'h00FF, 0);
		bus(0, 4'hF, 16'h0000, 0);
		arm_on(1);
		bus(0, TBR_OFS_COUNT, 16'h0000, 0);
		capture(10);
		bus(0, TBR_OFS_COUNT, 16'h000A, 0);
		bus(0, TBR_OFS_WORD_HI, 16'h0000, 1);
		capture(54);
		bus(0, TBR_OFS_COUNT, 16'h0080, 0);
		bus(0, TBR_OFS_WORD_HI, 16'h0000, 0);
		bus(0, TBR_OFS_WORD_LO, 16'h0000, 1);
		for (int i = 0; i < 65; i++) bus(0, TBR_OFS_WORD_HI, mem[i % 64], 1);
		arm_on(0);
		bus(0, TBR_OFS_COUNT, 16'h0000, 0);
		capture(70);
		bus(0, TBR_OFS_COUNT, 16'h0086, 0);
		sess <= 1'b0;
		// capture mode stays unchanged between recording and readout
		for (int i = 0; i < 3; i++) bus(0, TBR_OFS_WORD_HI, mem[i], 1);
		bus(1, TBR_OFS_CCH, 16'h005A, 0);
		bus(1, TBR_OFS_CCL, 16'h003C, 0);
		ccen <= 1'b1;
		// extended bits 5:0 match bits 7:2 of page 8'h2D; select bits 7:6 sweep all four values
		for (int ps = 0; ps < 4; ps++) begin
			bus(1, TBR_OFS_CCX, {8'h00, 2'(ps), 6'h0B}, 0);
			em += ps % 2;
			core(8'h2D, 16'h9A3C, em);
			em += 1 - ps % 2;
			core(8'hFF, 16'h5A3C, em);
		end
		loop1 <= 1'b1;
		core(8'h2D, 16'h9A3C, em + 1);
		`CHK("disarm", 1, n_dis)
		`CHK("break", 5, n_brk)
		complete_run();
	end
endmodule : tbr_trace_readout_tb_top
